// ### logic/sdc_regs.svh
// Behaviour
// - rising conversion clock powers up, starts conversion
// - clock edges ignored while converting
// - host drops conversion clock after completion
// - busy high exactly while converting
// - after completion core off, acquisition begins
// - conversion ends within 460 ns
// - starts no faster than 1.6 Msps, 152 ns acquisition
// - previous results stay readable while powered down
// - host keeps serial outputs quiet when down
// - each core word enters filter once
// - down-sampler keeps one of every factor
// - output rate is conversion rate over factor
// - two straps select factor 4, 8, 16, 32
// - filter runs per conversion, lowpass below half output
// - filter response repeats at conversion rate multiples
// - data ready rises at start, falls at end
// - decimated register changes once per factor conversions
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SDC_WORD_W 24
`define SDC_ACC_W 29
`define SDC_TAPS 32
`define SDC_PTR_W 5
`define SDC_CNT_W 4
`define SDC_PER_W 16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SDC_CLK_NS 50
`define SDC_CONV_NS 460
`define SDC_CONV_CYC (`SDC_CONV_NS / `SDC_CLK_NS)
`define SDC_ACQ_NS 152
`define SDC_ACQ_CYC ((`SDC_ACQ_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_RATE_KSPS 1600
`define SDC_PERIOD_NS (1000000 / `SDC_RATE_KSPS)
`define SDC_PERIOD_CYC ((`SDC_PERIOD_NS + `SDC_CLK_NS - 1) / `SDC_CLK_NS)

// ----------------------------------------------------------------
// decimation factor encoding
// ----------------------------------------------------------------
`define SDC_SEL_DF4 2'h0
`define SDC_SEL_DF8 2'h1
`define SDC_SEL_DF16 2'h2
`define SDC_SEL_DF32 2'h3
`define SDC_DF4_LAST 5'h03
`define SDC_DF8_LAST 5'h07
`define SDC_DF16_LAST 5'h0F
`define SDC_DF32_LAST 5'h1F
`define SDC_DF_MIN_LOG 3'h2

// ----------------------------------------------------------------
// host register map, byte addresses
// ----------------------------------------------------------------
`define SDC_ADR_CTRL 5'h00
`define SDC_ADR_PERIOD 5'h04
`define SDC_ADR_STATE 5'h08
`define SDC_ADR_IRQ_STAT 5'h0C
`define SDC_ADR_IRQ_CLR 5'h10
`define SDC_ADR_IRQ_EN 5'h14
`define SDC_ADR_RESULT 5'h18
`define SDC_ADR_RAW 5'h1C
`define SDC_CTRL_RUN 0
`define SDC_CTRL_STRAP_LO 1
`define SDC_CTRL_STRAP_HI 2
`define SDC_EV_RESULT 0
`define SDC_EV_DONE 1
`define SDC_ST_BUSY 0
`define SDC_ST_READY 1
`define SDC_ST_ACTIVE 2
`define SDC_CTRL_RST 3'h0
`define SDC_IRQ_RST 2'h0

`endif

// ### logic/sdc_pkg.sv
package sdc_pkg;
  // one converted or filtered word
  typedef logic [23:0] sdc_word_t;
  // device conversion states
  typedef enum logic {DEV_IDLE, DEV_CONVERT} sdc_dev_state_t;
  // host sequencing states
  typedef enum logic [1:0] {HOST_IDLE, HOST_WAIT_BUSY, HOST_WAIT_DONE} sdc_host_state_t;
endpackage : sdc_pkg

// ### logic/sdc_link_if.sv
`timescale 1ns/1ps
interface sdc_link_if;
  import sdc_pkg::*;
  logic conv_clk; // conversion clock from host
  logic busy; // conversion in progress
  logic data_ready; // decimated update marker
  sdc_word_t dec_word; // decimated output register
  sdc_word_t raw_word; // last raw core word
  logic factor_strap_low; // factor select bit 0
  logic factor_strap_high; // factor select bit 1
  modport dev (input conv_clk, factor_strap_low, factor_strap_high,
    output busy, data_ready, dec_word, raw_word);
  modport host (output conv_clk, factor_strap_low, factor_strap_high,
    input busy, data_ready, dec_word, raw_word);
endinterface : sdc_link_if

// ### logic/sdc_device.sv
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_device import sdc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  sdc_link_if.dev link,
  input sdc_word_t core_sample_i,
  output logic core_powered_o,
  output sdc_word_t filter_word_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic conv_meta; // first synchroniser stage
  logic conv_sync; // second synchroniser stage
  logic conv_prev; // delayed copy for edge detect
  logic [1:0] strap_meta; // strap first stage
  logic [1:0] strap_sync; // strap second stage
  logic [1:0] factor_sel; // held factor selection
  sdc_dev_state_t state; // conversion state
  logic [`SDC_CNT_W-1:0] conv_cnt; // cycles left in conversion
  sdc_word_t held_sample; // sample caught at start
  sdc_word_t taps [`SDC_TAPS]; // filter history
  logic [`SDC_PTR_W-1:0] wr_ptr; // next history slot
  logic [`SDC_ACC_W-1:0] acc; // running window sum
  logic [`SDC_PTR_W-1:0] dec_cnt; // position in decimation group
  logic [`SDC_PTR_W-1:0] dec_last; // last position in group
  logic [`SDC_PTR_W-1:0] old_ptr; // slot leaving the window
  logic [`SDC_ACC_W-1:0] next_acc; // window sum with new word
  sdc_word_t next_filter; // scaled window mean
  logic [2:0] shift; // log2 of factor
  logic start; // accepted conversion start
  logic done; // last cycle of conversion

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  // conversion clock pin, two flops then edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_meta <= 1'b0;
      conv_sync <= 1'b0;
      conv_prev <= 1'b0;
    end else begin
      conv_meta <= link.conv_clk;
      conv_sync <= conv_meta;
      conv_prev <= conv_sync;
    end
  end

  // strap pins, two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
    end else begin
      strap_meta <= {link.factor_strap_high, link.factor_strap_low};
      strap_sync <= strap_meta;
    end
  end

  // factor only follows the straps between conversions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      factor_sel <= `SDC_SEL_DF4;
    end else if (state == DEV_IDLE) begin
      factor_sel <= strap_sync;
    end
  end

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------

  // a rising edge counts only while idle
  assign start = conv_sync & ~conv_prev & (state == DEV_IDLE);
  // conversion ends when the countdown runs out
  assign done = (state == DEV_CONVERT) && (conv_cnt == '0);

  // conversion state and countdown
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= DEV_IDLE;
      conv_cnt <= '0;
    end else begin
      case (state)
        DEV_IDLE: begin
          if (start) begin
            state <= DEV_CONVERT;
            // busy spans the full trimmed conversion time
            conv_cnt <= `SDC_CNT_W'(`SDC_CONV_CYC - 1);
          end
        end
        DEV_CONVERT: begin
          // edges seen here are dropped
          if (done) begin
            state <= DEV_IDLE;
          end else begin
            conv_cnt <= conv_cnt - 1'b1;
          end
        end
        default: begin
          state <= DEV_IDLE;
        end
      endcase
    end
  end

  // busy and core power follow the conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.busy <= 1'b0;
      core_powered_o <= 1'b0;
    end else if (start) begin
      link.busy <= 1'b1;
      core_powered_o <= 1'b1;
    end else if (done) begin
      link.busy <= 1'b0;
      core_powered_o <= 1'b0;
    end
  end

  // input is acquired until the starting edge, then held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_sample <= '0;
    end else if (start) begin
      held_sample <= core_sample_i;
    end
  end

  // raw result of the last conversion, kept while powered down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.raw_word <= '0;
    end else if (done) begin
      link.raw_word <= held_sample;
    end
  end

  // ----------------------------------------------------------------
  // lowpass filter
  // ----------------------------------------------------------------

  // window length equals the decimation factor
  always_comb begin
    case (factor_sel)
      `SDC_SEL_DF4: dec_last = `SDC_DF4_LAST;
      `SDC_SEL_DF8: dec_last = `SDC_DF8_LAST;
      `SDC_SEL_DF16: dec_last = `SDC_DF16_LAST;
      `SDC_SEL_DF32: dec_last = `SDC_DF32_LAST;
      default: dec_last = `SDC_DF4_LAST;
    endcase
  end

  // moving average over the last factor words
  // nulls at multiples of rate over factor attenuate above half
  // the output rate; being sampled, the response repeats at
  // every multiple of the conversion rate
  always_comb begin
    old_ptr = wr_ptr + ~dec_last; // slot one window back
    next_acc = acc + {{(`SDC_ACC_W-`SDC_WORD_W){1'b0}}, held_sample}
      - {{(`SDC_ACC_W-`SDC_WORD_W){1'b0}}, taps[old_ptr]};
    shift = {1'b0, factor_sel} + `SDC_DF_MIN_LOG;
    next_filter = `SDC_WORD_W'(next_acc >> shift);
  end

  // history store, one word per conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `SDC_TAPS; i++) begin
        taps[i] <= '0;
      end
      wr_ptr <= '0;
    end else if (done) begin
      taps[wr_ptr] <= held_sample;
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // window sum and filter output update every conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= '0;
      filter_word_o <= '0;
    end else if (done) begin
      acc <= next_acc;
      filter_word_o <= next_filter;
    end
  end

  // ----------------------------------------------------------------
  // down-sampler
  // ----------------------------------------------------------------

  // position within the decimation group
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_cnt <= '0;
    end else if (done) begin
      if (dec_cnt >= dec_last) begin
        dec_cnt <= '0;
      end else begin
        dec_cnt <= dec_cnt + 1'b1;
      end
    end
  end

  // marker rises with the kept conversion, falls at its end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.data_ready <= 1'b0;
    end else if (start && dec_cnt == '0) begin
      link.data_ready <= 1'b1;
    end else if (done) begin
      link.data_ready <= 1'b0;
    end
  end

  // only the first word of each group reaches the output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.dec_word <= '0;
    end else if (done && dec_cnt == '0) begin
      link.dec_word <= next_filter;
    end
  end

endmodule : sdc_device

// ### logic/sdc_host.sv
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_host import sdc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  sdc_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [2:0] ctrl; // run and strap bits
  logic [`SDC_PER_W-1:0] period; // cycles between starts
  logic [1:0] irq_stat; // sticky events
  logic [1:0] irq_en; // event enables
  sdc_word_t result; // captured decimated word
  sdc_word_t raw; // captured raw word
  sdc_host_state_t state; // sequencer state
  logic [`SDC_PER_W-1:0] per_cnt; // start spacing countdown
  logic [`SDC_CNT_W-1:0] acq_cnt; // acquisition countdown
  logic ready_q; // delayed data ready
  logic [1:0] events; // this cycle's events
  logic wr; // register write strobe
  logic [1:0] clr; // clear mask from bus
  logic [`SDC_PER_W-1:0] gap; // clamped start spacing

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign clr = (wr && wb_adr_i == `SDC_ADR_IRQ_CLR && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;

  // single-cycle acknowledge and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        `SDC_ADR_CTRL: wb_dat_o <= {29'h0, ctrl};
        `SDC_ADR_PERIOD: wb_dat_o <= {16'h0, period};
        `SDC_ADR_STATE: wb_dat_o <= {29'h0, state != HOST_IDLE, link.data_ready, link.busy};
        `SDC_ADR_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat};
        `SDC_ADR_IRQ_EN: wb_dat_o <= {30'h0, irq_en};
        `SDC_ADR_RESULT: wb_dat_o <= {8'h0, result};
        `SDC_ADR_RAW: wb_dat_o <= {8'h0, raw};
        default: wb_dat_o <= '0; // unmapped and write-only read zero
      endcase
    end
  end

  // writable registers, low byte lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `SDC_CTRL_RST;
      period <= `SDC_PER_W'(`SDC_PERIOD_CYC);
      irq_en <= `SDC_IRQ_RST;
    end else if (wr) begin
      if (wb_adr_i == `SDC_ADR_CTRL && wb_sel_i[0]) ctrl <= wb_dat_i[2:0];
      if (wb_adr_i == `SDC_ADR_IRQ_EN && wb_sel_i[0]) irq_en <= wb_dat_i[1:0];
      if (wb_adr_i == `SDC_ADR_PERIOD && wb_sel_i[0]) period[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == `SDC_ADR_PERIOD && wb_sel_i[1]) period[15:8] <= wb_dat_i[15:8];
    end
  end

  // sticky events, a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= `SDC_IRQ_RST;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~clr) | events;
      irq_o <= |(((irq_stat & ~clr) | events) & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // never start faster than the top conversion rate
  assign gap = (period < `SDC_PER_W'(`SDC_PERIOD_CYC)) ? `SDC_PER_W'(`SDC_PERIOD_CYC) : period;

  // events from the device outputs
  always_comb begin
    events = 2'h0;
    events[`SDC_EV_DONE] = (state == HOST_WAIT_DONE) && !link.busy;
    events[`SDC_EV_RESULT] = ready_q && !link.data_ready;
  end

  // clock edges, spacing and result capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= HOST_IDLE;
      link.conv_clk <= 1'b0;
      per_cnt <= '0;
      acq_cnt <= '0;
      ready_q <= 1'b0;
      result <= '0;
      raw <= '0;
      link.factor_strap_low <= 1'b0;
      link.factor_strap_high <= 1'b0;
    end else begin
      ready_q <= link.data_ready;
      link.factor_strap_low <= ctrl[`SDC_CTRL_STRAP_LO];
      link.factor_strap_high <= ctrl[`SDC_CTRL_STRAP_HI];
      if (per_cnt != '0) per_cnt <= per_cnt - 1'b1;
      if (acq_cnt != '0) acq_cnt <= acq_cnt - 1'b1;
      if (events[`SDC_EV_RESULT]) result <= link.dec_word;
      case (state)
        HOST_IDLE: begin
          if (ctrl[`SDC_CTRL_RUN] && per_cnt == '0 && acq_cnt == '0) begin
            link.conv_clk <= 1'b1;
            per_cnt <= gap - 1'b1;
            state <= HOST_WAIT_BUSY;
          end
        end
        HOST_WAIT_BUSY: begin
          if (link.busy) state <= HOST_WAIT_DONE;
        end
        HOST_WAIT_DONE: begin
          if (!link.busy) begin
            link.conv_clk <= 1'b0;
            raw <= link.raw_word;
            acq_cnt <= `SDC_CNT_W'(`SDC_ACQ_CYC);
            state <= HOST_IDLE;
          end
        end
        default: state <= HOST_IDLE;
      endcase
    end
  end

endmodule : sdc_host

// ### dv/sdc_link_checker.sv
`timescale 1ns/1ps
module sdc_link_checker import sdc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic conv_clk,
  input wire logic busy,
  input wire logic data_ready,
  input wire sdc_word_t dec_word,
  input wire sdc_word_t raw_word,
  input wire logic factor_strap_low,
  input wire logic factor_strap_high
);
  // ----------------------------------------------------------------
  // helpers: cycles since the last conversion clock rise, busy run length
  // ----------------------------------------------------------------
  logic conv_q; // conversion clock one cycle ago
  logic [4:0] since; // saturating gap count
  logic rise; // conversion clock rising this cycle
  logic [4:0] busy_len; // consecutive busy cycles, saturating
  assign rise = conv_clk && !conv_q;

  // count how long busy has stood, cleared while low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_len <= 5'h00;
    end else if (!busy) begin
      busy_len <= 5'h00;
    end else if (busy_len != 5'h1F) begin
      busy_len <= busy_len + 5'h01;
    end
  end
  // track the gap between starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_q <= 1'b0;
      since <= 5'h1F;
    end else begin
      conv_q <= conv_clk;
      if (rise) begin
        since <= 5'h01;
      end else if (since != 5'h1F) begin
        since <= since + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  start_latency_a: assert property ($rose(conv_clk) && !busy |-> !busy[*3] ##1 busy)
    else $error("conversion did not start three cycles after clock rise");
  busy_cause_a: assert property ($rose(busy) |-> $past(conv_clk, 3) && !$past(conv_clk, 4))
    else $error("busy rose without a fresh conversion clock edge");
  busy_length_a: assert property ($fell(busy) |-> busy_len == 5'h09)
    else $error("busy not high for exactly nine cycles");
  busy_max_a: assert property (busy |-> busy_len < 5'h09)
    else $error("busy stood longer than the conversion time");
  acq_gap_a: assert property ($fell(busy) |-> !busy[*4])
    else $error("acquisition gap shorter than four cycles");
  rate_limit_a: assert property (rise |-> since >= 5'h0D)
    else $error("conversions started closer than thirteen cycles");
  clock_fall_a: assert property ($fell(conv_clk) |-> !busy)
    else $error("conversion clock fell during a conversion");
  ready_start_a: assert property ($rose(data_ready) |-> $rose(busy))
    else $error("data ready rose away from a conversion start");
  ready_frame_a: assert property (data_ready |-> busy)
    else $error("data ready did not frame the kept conversion");
  ready_end_a: assert property ($fell(busy) |-> !data_ready)
    else $error("data ready outlived the kept conversion");
  dec_update_a: assert property (!$stable(dec_word) |-> $fell(busy) && $past(data_ready))
    else $error("decimated word changed outside a kept conversion end");
  raw_update_a: assert property (!$stable(raw_word) |-> $fell(busy))
    else $error("raw word changed outside a conversion end");
  link_quiet_a: assert property (!busy && !$past(busy) |-> $stable(raw_word) && $stable(dec_word))
    else $error("result words moved while the core was powered down");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  cover property ($fell(busy));
  cover property ($rose(data_ready));
  cover property (!$stable(dec_word));
  cover property (factor_strap_high && factor_strap_low && $rose(data_ready));
endmodule : sdc_link_checker

// ### dv/tb.sv
`timescale 1ns/1ps
`include "sdc_regs.svh"
module tb import sdc_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam sdc_word_t SAMPLE = 24'h5A5A40; // core word, low bits clear
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [4:0] wb_adr = 5'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic irq;
  sdc_word_t core_sample = 24'h0;
  logic core_powered;
  sdc_word_t filter_word;
  logic busy_q = 1'b0; // busy one cycle ago
  logic dr_q = 1'b0; // data ready one cycle ago
  int n_conv = 0; // conversions seen
  int n_ready = 0; // data ready pulses seen
  int fails = 0;
  int n_checks = 0;

  always #25 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // design and checker
  // ----------------------------------------------------------------
  sdc_link_if intf ();
  sdc_device sdc_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(intf.dev),
    .core_sample_i(core_sample), .core_powered_o(core_powered), .filter_word_o(filter_word));
  sdc_host sdc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(intf.host), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq));
  sdc_link_checker sdc_link_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .conv_clk(intf.conv_clk), .busy(intf.busy), .data_ready(intf.data_ready),
    .dec_word(intf.dec_word), .raw_word(intf.raw_word),
    .factor_strap_low(intf.factor_strap_low), .factor_strap_high(intf.factor_strap_high));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
      fails++;
    end
  endtask : check

  // one classic cycle, entered right after a rising edge
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat,
    output logic [31:0] rd);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      $display("FAIL bus ack expected 1 seen %0h", wb_ack);
      fails++;
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // read a register and compare its low word
  task automatic rdchk(input logic [4:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    wb(1'b0, adr, 32'h0, rd);
    check(what, exp, {8'h00, rd[23:0]});
  endtask : rdchk

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  // wait until n conversions have started and the last one ended
  task automatic wait_conv(input int n);
    int k;
    k = 0;
    while ((n_conv < n || intf.busy !== 1'b0) && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 3000) begin
      $display("FAIL conversion count expected %0d seen %0d", n, n_conv);
      fails++;
    end
  endtask : wait_conv

  // ----------------------------------------------------------------
  // link monitor: counts starts and kept conversions
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    busy_q <= intf.busy;
    dr_q <= intf.data_ready;
    if (rst_i) begin
      n_conv <= 0;
      n_ready <= 0;
    end else begin
      if (intf.busy && !busy_q) n_conv <= n_conv + 1;
      if (intf.data_ready && !dr_q) n_ready <= n_ready + 1;
      if (intf.busy && busy_q) check("core powered", 32'h1, core_powered);
      else if (!intf.busy && !busy_q) check("core off", 32'h0, core_powered);
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    logic [31:0] rd;
    rdchk(`SDC_ADR_CTRL, 32'h0, "ctrl reset");
    rdchk(`SDC_ADR_PERIOD, 32'h0000000D, "period reset");
    rdchk(`SDC_ADR_IRQ_EN, 32'h0, "irq enable reset");
    rdchk(`SDC_ADR_IRQ_STAT, 32'h0, "irq status reset");
    wb(1'b1, `SDC_ADR_STATE, 32'h7, rd);
    rdchk(`SDC_ADR_STATE, 32'h0, "state read only");
    check("irq reset", 32'h0, irq);
  endtask : test_reset_values

  // run one factor from reset and follow the decimation
  task automatic test_factor(input logic [1:0] code);
    int s;
    int f;
    logic [31:0] rd;
    s = 2 + code;
    f = 1 << s;
    do_reset();
    core_sample <= SAMPLE;
    wb(1'b1, `SDC_ADR_CTRL, {29'h0, code, 1'b1}, rd);
    check("strap pins", code, {intf.factor_strap_high, intf.factor_strap_low});
    wait_conv(1);
    check("filter first", SAMPLE >> s, filter_word);
    rdchk(`SDC_ADR_RESULT, SAMPLE >> s, "result first");
    rdchk(`SDC_ADR_RAW, SAMPLE, "raw word");
    wait_conv(2);
    check("filter second", ({1'b0, SAMPLE} << 1) >> s, filter_word);
    check("dec hold", SAMPLE >> s, intf.dec_word);
    wait_conv(f + 1);
    rdchk(`SDC_ADR_RESULT, SAMPLE, "result kept");
    wb(1'b1, `SDC_ADR_CTRL, {29'h0, code, 1'b0}, rd);
    repeat (4) @(posedge clk_i);
    wait_conv(0);
    check("ready count", (n_conv + f - 1) / f, n_ready);
  endtask : test_factor

  // status, enable and clear of the two events
  task automatic test_irq();
    logic [31:0] rd;
    rdchk(`SDC_ADR_IRQ_STAT, 32'h3, "events set");
    check("irq masked", 32'h0, irq);
    wb(1'b1, `SDC_ADR_IRQ_EN, 32'h3, rd);
    check("irq raised", 32'h1, irq);
    wb(1'b1, `SDC_ADR_IRQ_CLR, 32'h1, rd);
    rdchk(`SDC_ADR_IRQ_STAT, 32'h2, "result cleared");
    check("irq done held", 32'h1, irq);
    wb(1'b1, `SDC_ADR_IRQ_EN, 32'h1, rd);
    check("irq done masked", 32'h0, irq);
    wb(1'b1, `SDC_ADR_IRQ_CLR, 32'h2, rd);
    wb(1'b1, `SDC_ADR_IRQ_STAT, 32'h3, rd);
    rdchk(`SDC_ADR_IRQ_STAT, 32'h0, "all cleared");
  endtask : test_irq

  // ----------------------------------------------------------------
  // verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    do_reset();
    test_reset_values();
    for (int c = 0; c < 4; c++) begin
      test_factor(c[1:0]);
    end
    test_irq();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    $display("FAIL watchdog expected done seen running");
    fails++;
    summarize();
  end
endmodule : tb
